// file: core/spb_port_b_power_mgmt.sv
// Port B power management, soft reset, idle status and baud test register logic
`include "spb_defs.svh"

module spb_port_b_power_mgmt #(
    parameter int IDLE_TIMEOUT = `SPB_IDLE_TIMEOUT,
    parameter int SOFTRST_MIN  = `SPB_SOFTRST_MIN_CYC
) (
    input  wire logic               clock,
    input  wire logic               rst,
    input  wire logic               cfgAddr,
    input  wire logic               cfgWrStb,
    input  wire logic               cfgRdStb,
    input  wire logic [7:0]         cfgWdata,
    output logic [7:0]              cfgRdata,
    input  wire spb_pkg::spb_fifo_s fifoStat,
    input  wire logic               divisorLatchAccess,
    input  wire logic               baudClock,
    input  wire logic               uartSerialOut,
    output logic                    portBSerialOut,
    output logic                    portBEnable,
    output logic                    portBReset,
    output logic                    portBFlush,
    output logic                    portBPowerDown,
    output logic                    portBAutoPowerDown,
    output logic                    softResetShort
);

    // Index register and both configuration registers
    logic [7:0]                      index_ff;
    logic [`SPB_CFG_WIDTH-1:0]       config_ff;
    spb_pkg::spb_pm_s                pm_ff;
    logic                            idle_ff;
    spb_pkg::spb_pwr_e               pwr_ff;

    // Output flops
    logic [7:0]                      rdata_ff;
    logic                            sout_ff;
    logic                            enable_ff;
    logic                            reset_ff;
    logic                            flush_ff;
    logic                            pd_ff;
    logic                            apd_ff;

    // Next values
    logic [7:0]                      nxt_index;
    logic [`SPB_CFG_WIDTH-1:0]       nxt_config;
    spb_pkg::spb_pm_s                nxt_pm;
    logic                            nxt_idle;
    spb_pkg::spb_pwr_e               nxt_pwr;
    logic [7:0]                      nxt_rdata;
    logic                            nxt_sout;

    // Helper wires
    logic                            timerIdle;
    logic                            shortFlag;
    logic [7:0]                      tgtRead;

    // Address decode of the index/target pair
    wire idxWr  = cfgWrStb & ~cfgAddr;
    wire tgtWr  = cfgWrStb & cfgAddr;
    wire wrCfg  = tgtWr & (index_ff == `SPB_IDX_CONFIG);
    wire wrPm   = tgtWr & (index_ff == `SPB_IDX_PMSTAT);
    wire rdPm   = cfgRdStb & cfgAddr & (index_ff == `SPB_IDX_PMSTAT);
    wire portEn = config_ff[`SPB_BIT_ENABLE];
    wire testOn = pm_ff.testEn & divisorLatchAccess;

    // Quiet timer; a soft reset or a flush restarts it
    spb_idle_timer #(
        .CNT (IDLE_TIMEOUT)
    ) u_idle (
        .clock (clock),
        .rst   (rst),
        .clear (pm_ff.softRst | pm_ff.dpdn),
        .fifo  (fifoStat),
        .idle  (timerIdle)
    );

    // Watches software's soft reset pulse width; the device cannot
    // stretch it, so a short pulse is only reported
    spb_min_hold #(
        .MIN (SOFTRST_MIN)
    ) u_hold (
        .clock    (clock),
        .rst      (rst),
        .level    (pm_ff.softRst),
        .tooShort (shortFlag)
    );

    // Index register takes any write to the index address
    assign nxt_index = idxWr ? cfgWdata : index_ff;

    // Companion config: enable plus stored select bits
    assign nxt_config = wrCfg ? cfgWdata[`SPB_CFG_WIDTH-1:0] : config_ff;

    // Power management write; idle bit and upper bits are dropped
    always_comb begin
        nxt_pm = pm_ff;
        if (wrPm) begin
            nxt_pm.testEn  = cfgWdata[`SPB_BIT_TEST];
            nxt_pm.apdEn   = cfgWdata[`SPB_BIT_APD];
            nxt_pm.softRst = cfgWdata[`SPB_BIT_RST];
            // Soft reset also releases direct powerdown
            nxt_pm.dpdn    = cfgWdata[`SPB_BIT_RST] ? 1'b0
                             : cfgWdata[`SPB_BIT_DPDN];
        end
    end

    // Idle flag frozen in direct powerdown, else tracks the timer
    assign nxt_idle = (pwr_ff == spb_pkg::SPB_DIRECT_PD) ? idle_ff
                      : timerIdle;

    // Power state selection
    always_comb begin
        nxt_pwr = spb_pkg::SPB_ACTIVE;
        if (nxt_pm.dpdn) begin
            nxt_pwr = spb_pkg::SPB_DIRECT_PD;
        end else if (pm_ff.apdEn & timerIdle & ~pm_ff.softRst) begin
            nxt_pwr = spb_pkg::SPB_AUTO_PD;
        end
    end

    // Powerdown readback muxed with the port enable
    assign tgtRead = (index_ff == `SPB_IDX_CONFIG) ? {3'h0, config_ff} :
                     (index_ff == `SPB_IDX_PMSTAT) ?
                     {3'h0, pm_ff.testEn, pm_ff.apdEn, pm_ff.softRst,
                      idle_ff, pm_ff.dpdn | ~portEn} : 8'h00;

    // Read data latches on a read strobe and then stands
    assign nxt_rdata = ~cfgRdStb ? rdata_ff : cfgAddr ? tgtRead : index_ff;

    // Test mode routes the baud clock to the serial pin
    assign nxt_sout = testOn ? baudClock : uartSerialOut;

    // Register state
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            index_ff  <= `SPB_INDEX_RST;
            config_ff <= `SPB_CONFIG_RST;
            pm_ff     <= '0;
            idle_ff   <= 1'b0;
            pwr_ff    <= spb_pkg::SPB_ACTIVE;
        end else begin
            index_ff  <= nxt_index;
            config_ff <= nxt_config;
            pm_ff     <= nxt_pm;
            idle_ff   <= nxt_idle;
            pwr_ff    <= nxt_pwr;
        end
    end

    // Output flops; hard reset holds the port in reset with a high line
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_ff  <= 8'h00;
            sout_ff   <= 1'b1;
            enable_ff <= 1'b0;
            reset_ff  <= 1'b1;
            flush_ff  <= 1'b0;
            pd_ff     <= 1'b0;
            apd_ff    <= 1'b0;
        end else begin
            rdata_ff  <= nxt_rdata;
            sout_ff   <= nxt_sout;
            enable_ff <= nxt_config[`SPB_BIT_ENABLE];
            reset_ff  <= nxt_pm.softRst;
            flush_ff  <= (nxt_pwr == spb_pkg::SPB_DIRECT_PD);
            pd_ff     <= (nxt_pwr != spb_pkg::SPB_ACTIVE);
            apd_ff    <= (nxt_pwr == spb_pkg::SPB_AUTO_PD);
        end
    end

    // Ports straight from flops
    assign cfgRdata           = rdata_ff;
    assign portBSerialOut     = sout_ff;
    assign portBEnable        = enable_ff;
    assign portBReset         = reset_ff;
    assign portBFlush         = flush_ff;
    assign portBPowerDown     = pd_ff;
    assign portBAutoPowerDown = apd_ff;
    assign softResetShort     = shortFlag;

    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    test_out_a: assert property (testOn |=> portBSerialOut == $past(baudClock))
        else $error("baud clock not on serial pin");

    apd_off_a: assert property (!pm_ff.apdEn |=> !portBAutoPowerDown)
        else $error("auto powerdown while disabled");

    apd_cond_a: assert property (portBAutoPowerDown |-> $past(fifoStat.txEmpty && fifoStat.rxEmpty))
        else $error("auto powerdown with data in FIFOs");

    soft_reset_a: assert property (wrPm && cfgWdata[2] |=> portBReset [*2])
        else $error("soft reset not held");

    idle_rise_a: assert property ($rose(idle_ff) |-> $past(timerIdle))
        else $error("idle set without idle condition");

    idle_hold_a: assert property (pwr_ff == spb_pkg::SPB_DIRECT_PD && $past(pwr_ff) == spb_pkg::SPB_DIRECT_PD
                                  |-> $stable(idle_ff))
        else $error("idle changed in direct powerdown");

    dpdn_write_a: assert property (wrPm && !cfgWdata[2] |=> pm_ff.dpdn == $past(cfgWdata[0]))
        else $error("powerdown bit not stored");

    rst_release_a: assert property (wrPm && cfgWdata[2] |=> !pm_ff.dpdn ##0 !portBFlush)
        else $error("soft reset left direct powerdown");

    flush_a: assert property (wrPm && !cfgWdata[2] && cfgWdata[0] |=> portBFlush && portBPowerDown)
        else $error("direct powerdown without flush");

    enable_keep_a: assert property (wrCfg && cfgWdata[0] && pm_ff.dpdn |=> pm_ff.dpdn)
        else $error("enable write cleared powerdown");

    read_mux_a: assert property (rdPm && !portEn |=> cfgRdata[0])
        else $error("powerdown read not forced while disabled");

    enable_out_a: assert property (wrCfg |=> portBEnable == $past(cfgWdata[0]))
        else $error("enable output wrong");

    reserved_zero_a: assert property (rdPm |=> cfgRdata[7:5] == 3'h0)
        else $error("reserved bits not zero");

    // Idle may only drop after the quiet condition went away
    idle_fall_a: assert property ($fell(idle_ff) |-> !$past(timerIdle))
        else $error("idle cleared while condition held");

    apd_timer_a: assert property (portBAutoPowerDown |-> $past(timerIdle && pm_ff.apdEn))
        else $error("auto powerdown without expired timer");

    timer_restart_a: assert property (fifoStat.activity |=> !timerIdle)
        else $error("activity did not restart timer");

    softrst_apd_a: assert property (pm_ff.softRst |=> !portBAutoPowerDown)
        else $error("auto powerdown during soft reset");

endmodule : spb_port_b_power_mgmt

// file: include/spb_defs.svh
// Offsets, field positions, reset values and timing counts for port B power control
`ifndef SPB_DEFS_SVH
`define SPB_DEFS_SVH
// Configuration indexes reached through the target port
`define SPB_IDX_CONFIG 8'h40
`define SPB_IDX_PMSTAT 8'h41
// Power management and status field positions
`define SPB_BIT_TEST 4
`define SPB_BIT_APD 3
`define SPB_BIT_RST 2
`define SPB_BIT_IDLE 1
`define SPB_BIT_DPDN 0
// Companion configuration field positions
`define SPB_BIT_ENABLE 0
`define SPB_CFG_WIDTH 5
// Reset values
`define SPB_CONFIG_RST 5'h00
`define SPB_INDEX_RST 8'h00
// Soft reset least active time, and its count at the core clock
`define SPB_SOFTRST_MIN_NS 1130
`define SPB_CLK_MHZ 40
`define SPB_SOFTRST_MIN_CYC ((`SPB_SOFTRST_MIN_NS * `SPB_CLK_MHZ + 999) / 1000)
// Idle timeout in core clock cycles
`define SPB_IDLE_TIMEOUT 1024
`endif

// file: include/spb_pkg.sv
// Types shared by the port B power management files
package spb_pkg;

    // Power state of the serial port
    typedef enum logic [1:0] {
        SPB_ACTIVE    = 2'b00,
        SPB_AUTO_PD   = 2'b01,
        SPB_DIRECT_PD = 2'b10
    } spb_pwr_e;

    // Software written power management controls
    typedef struct packed {
        logic testEn;
        logic apdEn;
        logic softRst;
        logic dpdn;
    } spb_pm_s;

    // FIFO status from the serial core
    typedef struct packed {
        logic txEmpty;
        logic rxEmpty;
        logic activity;
    } spb_fifo_s;

endpackage : spb_pkg

// file: core/spb_idle_timer.sv
// Idle timeout counter that restarts on any FIFO activity
module spb_idle_timer #(
    parameter int CNT = 1024
) (
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic              clear,
    input  wire spb_pkg::spb_fifo_s fifo,
    output logic                   idle
);
    localparam int W = $clog2(CNT + 1);
    localparam logic [W-1:0] LAST = W'(CNT);

    logic [W-1:0] count_ff;   // Cycles of quiet so far
    logic [W-1:0] nxt_count;
    wire          bothEmpty = fifo.txEmpty & fifo.rxEmpty;
    wire          expired   = (count_ff == LAST);

    // Any traffic or a non-empty FIFO restarts the timeout
    assign nxt_count = (clear | fifo.activity | ~bothEmpty) ? '0 :
                       expired ? count_ff : count_ff + W'(1);

    // Idle means empty FIFOs and an expired timer
    assign idle = bothEmpty & expired;

    // Counter register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count_ff <= '0;
        end else begin
            count_ff <= nxt_count;
        end
    end

endmodule : spb_idle_timer

// file: core/spb_min_hold.sv
// Flags a level that falls before it has been held a least number of cycles
module spb_min_hold #(
    parameter int MIN = 46
) (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic level,
    output logic      tooShort
);
    localparam int W = $clog2(MIN + 1);
    localparam logic [W-1:0] LAST = W'(MIN);

    logic [W-1:0] held_ff;    // Cycles the level has stood
    logic         short_ff;   // Sticky short pulse flag
    wire          heldEnough = (held_ff == LAST);
    wire          fell       = ~level & (held_ff != '0);

    // Short flag is a status; a new pulse long enough clears it
    assign tooShort = short_ff;

    // Hold counter saturates at the least time
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            held_ff <= '0;
        end else if (~level) begin
            held_ff <= '0;
        end else if (~heldEnough) begin
            held_ff <= held_ff + W'(1);
        end
    end

    // Record whether the last pulse met the least time
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            short_ff <= 1'b0;
        end else if (fell) begin
            short_ff <= ~heldEnough;
        end
    end

endmodule : spb_min_hold

// file: bench/spb_host_model.sv
// Host software model driving the index/target configuration port
module spb_host_model (
    input  wire logic       clock,
    output logic            cfgAddr,
    output logic            cfgWrStb,
    output logic            cfgRdStb,
    output logic [7:0]      cfgWdata,
    input  wire logic [7:0] cfgRdata
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus at time zero
    initial begin
        cfgAddr  = 1'b0;
        cfgWrStb = 1'b0;
        cfgRdStb = 1'b0;
        cfgWdata = 8'h00;
    end

    // Index then target write, strobe held over both edges
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        @(negedge clock);
        cfgAddr  = 1'b0;
        cfgWrStb = 1'b1;
        cfgWdata = idx;
        @(negedge clock);
        cfgAddr  = 1'b1;
        cfgWdata = d;
        @(negedge clock);
        cfgWrStb = 1'b0;
        // Unqualified data shows a changed value, not the last one
        cfgWdata = ~d;
    endtask : wr

    // Index write then target read; data taken once registered
    task automatic rd(input logic [7:0] idx, output logic [7:0] d);
        @(negedge clock);
        cfgAddr  = 1'b0;
        cfgWrStb = 1'b1;
        cfgWdata = idx;
        @(negedge clock);
        cfgWrStb = 1'b0;
        cfgWdata = ~idx;
        cfgAddr  = 1'b1;
        cfgRdStb = 1'b1;
        @(negedge clock);
        cfgRdStb = 1'b0;
        d        = cfgRdata;
    endtask : rd
endmodule : spb_host_model

// file: bench/spb_port_b_power_mgmt_tb_top.sv
// Self-checking bench for port B power management register logic
module spb_port_b_power_mgmt_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int         TMO = 16;    // Short idle timeout keeps the run brief
    localparam int         SRM = 12;    // Soft reset minimum; the 8-cycle pulse must fall short of it
    localparam logic [7:0] PM  = 8'h41; // Power management index
    localparam logic [7:0] CF  = 8'h40; // Companion config index
    logic clock = 1'b0, rst = 1'b1, cfgAddr, cfgWrStb, cfgRdStb;
    logic [7:0] cfgWdata, cfgRdata;
    spb_pkg::spb_fifo_s fifoStat = 3'b100;    // Receive side not empty at start
    logic divisorLatchAccess = 1'b0, baudClock = 1'b0, uartSerialOut = 1'b1;
    logic portBSerialOut, portBEnable, portBReset, portBFlush, portBPowerDown;
    logic portBAutoPowerDown, softResetShort, baudQ, uartQ;
    int   bad_count = 0, num_checks = 0, tick = 0;

    always #12.5 clock = ~clock;

    // Baud and serial sources at different rates so paths differ
    always @(negedge clock) begin
        tick          <= tick + 1;
        baudClock     <= (tick % 4) < 2;
        uartSerialOut <= (tick % 6) < 3;
    end
    // Copies one edge late, as the output path is registered
    always @(posedge clock) begin
        baudQ <= baudClock;
        uartQ <= uartSerialOut;
    end

    spb_host_model host_u (.clock(clock), .cfgAddr(cfgAddr), .cfgWrStb(cfgWrStb),
        .cfgRdStb(cfgRdStb), .cfgWdata(cfgWdata), .cfgRdata(cfgRdata));
    spb_port_b_power_mgmt #(.IDLE_TIMEOUT(TMO), .SOFTRST_MIN(SRM)) dut_u (.clock(clock), .rst(rst),
        .cfgAddr(cfgAddr), .cfgWrStb(cfgWrStb), .cfgRdStb(cfgRdStb), .cfgWdata(cfgWdata),
        .cfgRdata(cfgRdata), .fifoStat(fifoStat), .divisorLatchAccess(divisorLatchAccess),
        .baudClock(baudClock), .uartSerialOut(uartSerialOut), .portBSerialOut(portBSerialOut),
        .portBEnable(portBEnable), .portBReset(portBReset), .portBFlush(portBFlush),
        .portBPowerDown(portBPowerDown), .portBAutoPowerDown(portBAutoPowerDown),
        .softResetShort(softResetShort));

    // Compare and count
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask : cyc
    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp, input string nm);
        logic [7:0] v;
        host_u.rd(idx, v);
        chk(nm, v, exp);
    endtask : rdchk

    // Values straight after hard reset
    task automatic t_reset();
        rdchk(PM, 8'h01, "pmAfterReset");
        rdchk(CF, 8'h00, "cfgAfterReset");
        host_u.wr(8'h42, 8'hff);
        rdchk(8'h42, 8'h00, "unmapped");
    endtask : t_reset

    // Enable and powerdown in every combination; dpdn stored first, then enable
    task automatic t_enable();
        logic [1:0] cmb [4] = '{2'b00, 2'b01, 2'b11, 2'b10}; // {enable, dpdn}
        for (int i = 0; i < 4; i++) begin
            host_u.wr(PM, {7'h0, cmb[i][0]});
            host_u.wr(CF, {7'h0, cmb[i][1]});
            rdchk(CF, {7'h0, cmb[i][1]}, "enableRd");
            rdchk(PM, {7'h0, cmb[i][0] | ~cmb[i][1]}, "dpdnRd");
            chk("powerDown", portBPowerDown, cmb[i][0]);
            chk("flush", portBFlush, cmb[i][0]);
            chk("enable", portBEnable, cmb[i][1]);
        end
    endtask : t_enable

    // Idle flag and auto powerdown against FIFO state and timer
    task automatic t_idle();
        fifoStat = 3'b110;
        host_u.wr(PM, 8'h08);
        cyc(TMO / 2);
        chk("apdEarly", portBAutoPowerDown, 1'b0);
        cyc(TMO);
        rdchk(PM, 8'h0a, "idleSet");
        chk("apdOn", portBAutoPowerDown, 1'b1);
        chk("pdAuto", portBPowerDown, 1'b1);
        fifoStat = 3'b100;
        cyc(TMO + 4);
        rdchk(PM, 8'h08, "idleRxBusy");
        chk("apdRxBusy", portBAutoPowerDown, 1'b0);
        fifoStat = 3'b110;
        cyc(TMO + 4);
        fifoStat = 3'b111;
        cyc(1);
        fifoStat = 3'b110;
        rdchk(PM, 8'h08, "idleRestart");
        // Reserved and idle bits written, auto powerdown off
        host_u.wr(PM, 8'he2);
        cyc(TMO + 4);
        rdchk(PM, 8'h02, "idleNoApd");
        chk("apdOff", portBAutoPowerDown, 1'b0);
        // Idle seen first, so the flush loses nothing
        host_u.wr(PM, 8'h01);
        fifoStat = 3'b000;
        cyc(4);
        rdchk(PM, 8'h03, "idleFrozen");
        host_u.wr(PM, 8'h00);
        rdchk(PM, 8'h00, "idleFollows");
    endtask : t_idle

    // Soft reset leaves direct powerdown; short and long pulses
    task automatic t_softrst();
        host_u.wr(PM, 8'h01);
        host_u.wr(PM, 8'h05);
        cyc(2);
        chk("resetHeld", portBReset, 1'b1);
        chk("pdLeft", portBPowerDown, 1'b0);
        rdchk(PM, 8'h04, "dpdnCleared");
        host_u.wr(PM, 8'h00);
        cyc(2);
        chk("shortPulse", softResetShort, 1'b1);
        chk("resetGone", portBReset, 1'b0);
        host_u.wr(PM, 8'h04);
        cyc(SRM + 4);
        host_u.wr(PM, 8'h00);
        cyc(2);
        chk("longPulse", softResetShort, 1'b0);
    endtask : t_softrst

    // Baud clock shown only with test bit and divisor latch both set
    task automatic t_test();
        for (int i = 0; i < 3; i++) begin
            divisorLatchAccess = (i != 1);
            host_u.wr(PM, {3'h0, i != 2, 4'h0});
            cyc(2);
            repeat (8) begin
                cyc(1);
                chk("serialOut", portBSerialOut, (i == 0) ? baudQ : uartQ);
            end
        end
    endtask : t_test

    // Hard reset in mid-run clears a set idle flag
    task automatic t_hardrst();
        fifoStat = 3'b110;
        cyc(TMO + 4);
        rdchk(PM, 8'h02, "idleBefore");
        rst = 1'b1;
        cyc(2);
        rst = 1'b0;
        rdchk(PM, 8'h01, "idleCleared");
        chk("enableCleared", portBEnable, 1'b0);
    endtask : t_hardrst

    task automatic summarize();
        $display("Checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize

    // Main sequence
    initial begin
        cyc(8);
        rst = 1'b0;
        t_reset();
        t_enable();
        t_idle();
        t_softrst();
        t_test();
        t_hardrst();
        summarize();
    end
    // Watchdog, well beyond the few hundred cycles expected
    initial begin
        repeat (3000) @(posedge clock);
        bad_count++;
        summarize();
    end
endmodule : spb_port_b_power_mgmt_tb_top
